// File: inc/sd_gap_ctrl_map.vh
// Purpose: offsets, field positions, reset values and codes of the gap/power control block
// Assumes: byte addresses on an 8-bit avalon address, 32-bit data
// Notes:   definitions only
`ifndef SD_GAP_CTRL_MAP_VH
`define SD_GAP_CTRL_MAP_VH

// register byte offsets
`define CTRL_OFFSET      8'h28
`define STAT_OFFSET      8'hf0

// control register reset value and writable bits
`define CTRL_RESET       32'h0000_0000
`define CTRL_WMASK       32'h070f_0f07

// control register field positions
`define BIT_WAKE_REMOVE  26
`define BIT_WAKE_INSERT  25
`define BIT_WAKE_CARDINT 24
`define BIT_INT_AT_GAP   19
`define BIT_READ_WAIT    18
`define BIT_CONTINUE     17
`define BIT_STOP_AT_GAP  16
`define VSEL_HI          11
`define VSEL_LO          9
`define BIT_BUS_POWER    8
`define BIT_HIGH_SPEED   2
`define BIT_WIDTH4       1
`define BIT_LED          0

// bus voltage select codes
`define VSEL_3V3         3'h7
`define VSEL_3V0         3'h6
`define VSEL_1V8         3'h5

// status register field positions
`define ST_READ_ACTIVE   0
`define ST_WRITE_ACTIVE  1
`define ST_DAT_ACTIVE    2
`define ST_CMD_INH_DAT   3
`define ST_GAP_STOPPED   4
`define ST_SUPPLY_ON     5
`define ST_WAKE          6
`define ST_CARD_PRESENT  7
`define ST_STATE_LO      8
`define ST_STATE_HI      9

// data path states
`define DP_IDLE          2'h0
`define DP_ACTIVE        2'h1
`define DP_GAP           2'h2

`endif

// File: verilog/edge_sync.v
// Purpose: two-flop synchroniser with edge detection for pins
// Assumes: inputs asynchronous to core_clk
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module edge_sync #(
  parameter WIDTH = 2
) (
  input  wire             core_clk,
  input  wire             reset_n,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] level_out,
  output wire [WIDTH-1:0] rise_out,
  output wire [WIDTH-1:0] fall_out
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg meta_reg;
      reg sync_reg;
      reg last_reg;
      always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          meta_reg <= 1'b0;
          sync_reg <= 1'b0;
          last_reg <= 1'b0;
        end else begin
          meta_reg <= async_in[i];
          sync_reg <= meta_reg;
          last_reg <= sync_reg;
        end
      end
      assign level_out[i] = sync_reg;
      assign rise_out[i]  = sync_reg & ~last_reg;
      assign fall_out[i]  = ~sync_reg & last_reg;
    end
  endgenerate

endmodule // edge_sync

// File: verilog/sd_gap_power_ctrl.v
// Purpose: wake, block gap, bus power and host control register with its data path effects
// Assumes: avalon-mm slave with waitrequest; card clock and dat1 pins sampled by core_clk
// Notes:   transfer engine events arrive as same-clock pulses
//
// Behaviour
// - removal wake enable raises wake on removal
// - insertion wake enable raises wake on insertion
// - card interrupt wake enable raises wake
// - four-bit mode samples interrupts at gap
// - read wait drives dat2 in a read gap, else clock stops (read gaps only)
// - continue restarts, self-clears on activity rise
// - continue write ignored while stop set
// - stop request halts at next block gap
// - clearing both bits does not resume
// - stop request shapes present-state activity flags
// - voltage codes 111, 110, 101; others unpowered
// - no card clears bus power bit
// - high speed launches rising, else falling
// - width bit selects four or one bit
// - led bit drives activity lamp
// - data line reset clears continue and stop
`timescale 1ns/1ps
`include "sd_gap_ctrl_map.vh"
module sd_gap_power_ctrl (
  input  wire        core_clk,
  input  wire        reset_n,
  input  wire [7:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  input  wire        card_removal_status,
  input  wire        card_insertion_status,
  input  wire        card_interrupt_status,
  input  wire        card_present,
  input  wire [2:0]  voltage_support,
  input  wire        dat_soft_reset,
  input  wire        xfer_start,
  input  wire        xfer_is_read,
  input  wire        block_gap,
  input  wire        xfer_last_done,
  input  wire        sd_clk_pin,
  input  wire        dat1_pin,
  output reg         wake_event,
  output reg         bus_supply_en,
  output reg  [2:0]  bus_voltage_sel,
  output reg         led_on,
  output reg         width4_mode,
  output reg         launch_strobe,
  output reg         read_transfer_active,
  output reg         write_transfer_active,
  output reg         dat_line_active,
  output reg         cmd_inhibit_dat,
  output reg         xfer_complete,
  output reg         dat2_out,
  output reg         dat2_oe,
  output reg         card_clk_stop,
  output reg         gap_int_sample,
  output reg         card_int_at_gap
);

  reg  [31:0] ctrl_reg;
  reg  [31:0] ctrl_next;
  reg  [1:0]  state_reg;
  reg  [1:0]  state_next;
  reg         dir_read_reg;
  reg         dir_read_next;
  reg         cont_clear;
  reg  [31:0] lane_mask;
  reg  [31:0] merged;
  reg  [31:0] status_word;
  reg         supply_ok;
  wire        bus_req;
  wire        bus_fire;
  wire        ctrl_wr;
  wire        clk_rise;
  wire        clk_fall;
  wire        dat1_level;

  // byte enables to a bit mask
  function [31:0] be_mask;
    input [3:0] be;
    begin
      be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    end
  endfunction

  // address match against a register offset
  function addr_hit;
    input [7:0] addr;
    input [7:0] offset;
    begin
      addr_hit = (addr[7:2] == offset[7:2]);
    end
  endfunction

  // voltage code is a defined one and the host supports it
  function volt_ok;
    input [2:0] code;
    input [2:0] support;
    begin
      if (code == `VSEL_3V3) begin
        volt_ok = support[2];
      end else if (code == `VSEL_3V0) begin
        volt_ok = support[1];
      end else if (code == `VSEL_1V8) begin
        volt_ok = support[0];
      end else begin
        volt_ok = 1'b0;
      end
    end
  endfunction

  edge_sync #(
    .WIDTH     (1)
  ) u_clk_sync (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .async_in  (sd_clk_pin),
    .level_out (),
    .rise_out  (clk_rise),
    .fall_out  (clk_fall)
  );

  edge_sync #(
    .WIDTH     (1)
  ) u_dat1_sync (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .async_in  (dat1_pin),
    .level_out (dat1_level),
    .rise_out  (),
    .fall_out  ()
  );

  // avalon handshake: waitrequest drops one cycle after the request
  assign bus_req  = avs_read | avs_write;
  assign bus_fire = bus_req & ~avs_waitrequest;
  assign ctrl_wr  = bus_fire & avs_write & addr_hit(avs_address, `CTRL_OFFSET);

  // data path sequencing around block gaps
  always @* begin
    state_next    = state_reg;
    dir_read_next = dir_read_reg;
    case (state_reg)
      `DP_IDLE: begin
        if (xfer_start) begin
          state_next    = `DP_ACTIVE;
          dir_read_next = xfer_is_read;
        end
      end
      `DP_ACTIVE: begin
        if (xfer_last_done) begin
          state_next = `DP_IDLE;
        end else if (block_gap && ctrl_reg[`BIT_STOP_AT_GAP]) begin
          state_next = `DP_GAP;
        end
      end
      `DP_GAP: begin
        if (ctrl_reg[`BIT_CONTINUE] && !ctrl_reg[`BIT_STOP_AT_GAP]) begin
          state_next = `DP_ACTIVE;
        end
      end
      default: begin
        state_next = `DP_IDLE;
      end
    endcase
    if (dat_soft_reset) begin
      state_next = `DP_IDLE;
    end
  end

  // control register next value
  always @* begin
    lane_mask = be_mask(avs_byteenable);
    merged    = (ctrl_reg & ~lane_mask) | (avs_writedata & lane_mask);
    ctrl_next = ctrl_reg;
    // continue clears once the restarted transfer shows activity
    cont_clear = (state_reg == `DP_GAP) && (state_next == `DP_ACTIVE);
    if (cont_clear) begin
      ctrl_next[`BIT_CONTINUE] = 1'b0;
    end
    if (ctrl_wr) begin
      ctrl_next = (merged & `CTRL_WMASK) | (ctrl_next & ~`CTRL_WMASK & 32'h0000_0000);
      ctrl_next[`BIT_CONTINUE] = ctrl_reg[`BIT_CONTINUE] & ~cont_clear;
      if (lane_mask[`BIT_CONTINUE] && avs_writedata[`BIT_CONTINUE]
          && !ctrl_next[`BIT_STOP_AT_GAP]) begin
        ctrl_next[`BIT_CONTINUE] = 1'b1;
      end
    end
    if (!card_present) begin
      ctrl_next[`BIT_BUS_POWER] = 1'b0;
    end
    if (dat_soft_reset) begin
      ctrl_next[`BIT_CONTINUE]    = 1'b0;
      ctrl_next[`BIT_STOP_AT_GAP] = 1'b0;
    end
  end

  // own status word
  always @* begin
    status_word = 32'h0000_0000;
    status_word[`ST_READ_ACTIVE]  = read_transfer_active;
    status_word[`ST_WRITE_ACTIVE] = write_transfer_active;
    status_word[`ST_DAT_ACTIVE]   = dat_line_active;
    status_word[`ST_CMD_INH_DAT]  = cmd_inhibit_dat;
    status_word[`ST_GAP_STOPPED]  = (state_reg == `DP_GAP);
    status_word[`ST_SUPPLY_ON]    = bus_supply_en;
    status_word[`ST_WAKE]         = wake_event;
    status_word[`ST_CARD_PRESENT] = card_present;
    status_word[`ST_STATE_HI:`ST_STATE_LO] = state_reg;
    supply_ok = ctrl_reg[`BIT_BUS_POWER]
                & volt_ok(ctrl_reg[`VSEL_HI:`VSEL_LO], voltage_support);
  end

  // bus slave registers
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= ~(bus_req & avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        if (addr_hit(avs_address, `CTRL_OFFSET)) begin
          avs_readdata <= ctrl_reg & `CTRL_WMASK;
        end else if (addr_hit(avs_address, `STAT_OFFSET)) begin
          avs_readdata <= status_word;
        end else begin
          avs_readdata <= 32'h0000_0000;
        end
      end
    end
  end

  // control state and data path state
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg     <= `CTRL_RESET;
      state_reg    <= `DP_IDLE;
      dir_read_reg <= 1'b0;
    end else begin
      ctrl_reg     <= ctrl_next;
      state_reg    <= state_next;
      dir_read_reg <= dir_read_next;
    end
  end

  // registered outputs
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wake_event            <= 1'b0;
      bus_supply_en         <= 1'b0;
      bus_voltage_sel       <= 3'h0;
      led_on                <= 1'b0;
      width4_mode           <= 1'b0;
      launch_strobe         <= 1'b0;
      read_transfer_active  <= 1'b0;
      write_transfer_active <= 1'b0;
      dat_line_active       <= 1'b0;
      cmd_inhibit_dat       <= 1'b0;
      xfer_complete         <= 1'b0;
      dat2_out              <= 1'b0;
      dat2_oe               <= 1'b0;
      card_clk_stop         <= 1'b0;
      gap_int_sample        <= 1'b0;
      card_int_at_gap       <= 1'b0;
    end else begin
      wake_event <= (ctrl_reg[`BIT_WAKE_REMOVE] & card_removal_status)
                  | (ctrl_reg[`BIT_WAKE_INSERT] & card_insertion_status)
                  | (ctrl_reg[`BIT_WAKE_CARDINT] & card_interrupt_status);
      bus_supply_en   <= supply_ok & card_present;
      bus_voltage_sel <= ctrl_reg[`VSEL_HI:`VSEL_LO];
      led_on          <= ctrl_reg[`BIT_LED];
      width4_mode     <= ctrl_reg[`BIT_WIDTH4];
      launch_strobe   <= ctrl_reg[`BIT_HIGH_SPEED] ? clk_rise : clk_fall;
      read_transfer_active  <= (state_next == `DP_ACTIVE) & dir_read_next;
      write_transfer_active <= (state_next == `DP_ACTIVE) & ~dir_read_next;
      dat_line_active       <= (state_next == `DP_ACTIVE);
      cmd_inhibit_dat       <= (state_next == `DP_ACTIVE);
      xfer_complete <= (state_reg == `DP_ACTIVE) && (state_next != `DP_ACTIVE)
                       && !dat_soft_reset;
      // read wait holds dat2 low during a read gap stop
      dat2_oe  <= (state_next == `DP_GAP) & dir_read_next
                  & ctrl_reg[`BIT_READ_WAIT];
      dat2_out <= 1'b0;
      card_clk_stop <= (state_next == `DP_GAP) & dir_read_next
                       & ~ctrl_reg[`BIT_READ_WAIT];
      gap_int_sample <= (state_reg == `DP_GAP) & ctrl_reg[`BIT_INT_AT_GAP]
                        & ctrl_reg[`BIT_WIDTH4];
      card_int_at_gap <= (state_reg == `DP_GAP) & ctrl_reg[`BIT_INT_AT_GAP]
                         & ctrl_reg[`BIT_WIDTH4] & ~dat1_level;
    end
  end

endmodule // sd_gap_power_ctrl

// File: test/gap_ctrl_checker_assertions.sv
// Purpose: port checks of the gap and power control block
// Assumes: one core_clk domain, reset_n async low
// Notes: bound to the design from the bench
`timescale 1ns/1ps
module gap_ctrl_checker (
  input wire       core_clk,
  input wire       reset_n,
  input wire       avs_read,
  input wire       avs_write,
  input wire       avs_waitrequest,
  input wire       card_removal_status,
  input wire       card_insertion_status,
  input wire       card_interrupt_status,
  input wire       card_present,
  input wire       dat_soft_reset,
  input wire       wake_event,
  input wire       bus_supply_en,
  input wire [2:0] bus_voltage_sel,
  input wire       width4_mode,
  input wire       read_transfer_active,
  input wire       write_transfer_active,
  input wire       dat_line_active,
  input wire       cmd_inhibit_dat,
  input wire       xfer_complete,
  input wire       dat2_out,
  input wire       dat2_oe,
  input wire       card_clk_stop,
  input wire       gap_int_sample,
  input wire       card_int_at_gap
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest ##1 avs_waitrequest) else $error("bus answer");
  wake_cause_a: assert property (wake_event |->
    $past(card_removal_status || card_insertion_status || card_interrupt_status)
    || $past(card_removal_status || card_insertion_status || card_interrupt_status, 2))
    else $error("wake without cause");
  nocard_power_a: assert property (!card_present |=> !bus_supply_en)
    else $error("power without card");
  volt_code_a: assert property (bus_supply_en |-> bus_voltage_sel >= 3'h5)
    else $error("power on reserved code");
  read_wait_a: assert property (dat2_oe |->
    !dat2_out && !card_clk_stop && !read_transfer_active) else $error("read wait drive");
  clk_stop_a: assert property (card_clk_stop |-> !dat_line_active)
    else $error("clock stop while active");
  gap_sample_a: assert property (card_int_at_gap |-> gap_int_sample && width4_mode)
    else $error("gap interrupt sample");
  active_flags_a: assert property ((read_transfer_active || write_transfer_active)
    |-> dat_line_active && cmd_inhibit_dat) else $error("activity flags");
  complete_pulse_a: assert property (xfer_complete |->
    !dat_line_active && $past(dat_line_active)) else $error("complete pulse");
  soft_reset_a: assert property (dat_soft_reset |=> !dat_line_active)
    else $error("soft reset");
  cover property (wake_event);
  cover property (dat2_oe);
  cover property (card_clk_stop);
  cover property (card_int_at_gap);
endmodule // gap_ctrl_checker

// File: test/sd_card_model.sv
// Purpose: card side of the link, clock and interrupt line
// Assumes: 125 ns card clock, only while run is high
// Notes: dat1 is pulled up, low only while the card signals an interrupt
`timescale 1ns/1ps
module sd_card_model (
  input  wire run,
  input  wire irq,
  output reg  sd_clk_pin,
  output wire dat1_pin
);
  initial sd_clk_pin = 1'b0;
  always begin
    wait (run);
    #62.5 sd_clk_pin = 1'b1;
    #62.5 sd_clk_pin = 1'b0;
  end
  assign dat1_pin = irq ? 1'b0 : 1'b1;
endmodule // sd_card_model

// File: test/sd_host_gap_power_control_bench.sv
// Purpose: self-checking bench of the gap and power control block
// Assumes: 100 MHz core_clk, avalon master tasks
// Notes: model register kept in mc, random data from xorshift
`timescale 1ns/1ps
`include "sd_gap_ctrl_map.vh"
module sd_host_gap_power_control_bench;
  localparam int go = 0, gap = 1, last = 2, srst = 3;
  logic core_clk = 1'b0, reset_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic card_present = 1'b1, xfer_is_read = 1'b0, run = 1'b0, irq = 1'b0;
  logic [7:0] avs_address = '0;
  logic [31:0] avs_writedata = '0, rd, ctl, mc, seed = 32'h0000_1151;
  logic [3:0] avs_byteenable = '0, pv = '0;
  logic [2:0] st = '0, voltage_support = '0;
  wire card_removal_status = st[0], card_insertion_status = st[1];
  wire card_interrupt_status = st[2], xfer_start = pv[go], block_gap = pv[gap];
  wire xfer_last_done = pv[last], dat_soft_reset = pv[srst], sd_clk_pin, dat1_pin;
  wire [31:0] avs_readdata;
  wire [2:0] bus_voltage_sel;
  wire avs_waitrequest, wake_event, bus_supply_en, led_on, width4_mode, launch_strobe;
  wire read_transfer_active, write_transfer_active, dat_line_active, cmd_inhibit_dat;
  wire xfer_complete, dat2_out, dat2_oe, card_clk_stop, gap_int_sample, card_int_at_gap;
  int fails = 0, num_checks = 0, n;
  sd_gap_power_ctrl dut (.*);
  sd_card_model card (.run(run), .irq(irq), .sd_clk_pin(sd_clk_pin), .dat1_pin(dat1_pin));
  always #5 core_clk = ~core_clk;
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
  endtask
  task automatic chk(input string s, input [31:0] e, input [31:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic bus(input logic w, input [7:0] a, input [31:0] d, input [3:0] be);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    avs_byteenable <= be;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask
  function automatic [31:0] xs(input [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    xs = v;
  endfunction
  function automatic [31:0] mw(input [31:0] o, d, input [3:0] be);
    logic [31:0] m;
    for (int i = 0; i < 4; i++) m[i*8 +: 8] = {8{be[i]}};
    m = m & `CTRL_WMASK;
    mw = (o & ~m) | (d & m);
    mw[17] = o[17] | (mw[17] & !mw[16]);
  endfunction
  function automatic logic pw(input [31:0] c);
    pw = c[8] && card_present && (c[11:9] == 3'h7 ? voltage_support[2] :
      c[11:9] == 3'h6 ? voltage_support[1] : c[11:9] == 3'h5 && voltage_support[0]);
  endfunction
  task automatic wr(input [31:0] d, input [3:0] be);
    bus(1'b1, `CTRL_OFFSET, d, be);
    mc = mw(mc, d, be);
  endtask
  task automatic rdc;
    bus(1'b0, `CTRL_OFFSET, '0, 4'hf);
    chk("ctrl", mc, rd);
  endtask
  task automatic pulse(input int i);
    pv[i] <= 1'b1;
    tick(1);
    pv[i] <= 1'b0;
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #300000;
    fails++;
    finish_test();
  end
  initial begin
    tick(2);
    reset_n <= 1'b1;
    tick(1);
    mc = `CTRL_RESET;
    rdc();
    bus(1'b0, 8'h40, '0, 4'hf);
    chk("unmapped", '0, rd);
    for (int i = 0; i < 24; i++) begin
      seed = xs(seed);
      voltage_support <= seed[31:29];
      wr(seed & 32'hfffd_ffff, seed[7:4]);
      rdc();
      chk("led", mc[0], led_on);
      chk("width", mc[1], width4_mode);
      chk("vsel", mc[11:9], bus_voltage_sel);
      chk("supply", pw(mc), bus_supply_en);
    end
    voltage_support <= 3'h7;
    wr(32'h0000_0f00, 4'hf);
    card_present <= 1'b0;
    tick(3);
    mc[8] = 1'b0;
    rdc();
    chk("supply", 1'b0, bus_supply_en);
    card_present <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      wr((32'h0400_0000 >> i) | (i == 2 ? 32'h0000_0f00 : 32'h0), 4'hf);
      for (int s = 0; s < 3; s++) begin
        st <= 3'h1 << s;
        tick(3);
        chk("wake", i == s, wake_event);
      end
      st <= '0;
    end
    for (int k = 0; k < 3; k++) begin
      ctl = 32'h0009_0002 | (k == 0 ? 32'h0004_0000 : '0);
      wr(ctl, 4'hf);
      xfer_is_read <= k < 2;
      pulse(go);
      tick(2);
      chk("read act", k < 2, read_transfer_active);
      chk("write act", k == 2, write_transfer_active);
      chk("inhibit", 1'b1, cmd_inhibit_dat);
      pulse(gap);
      tick(1);
      chk("complete", 1'b1, xfer_complete);
      tick(1);
      chk("dat act", 1'b0, dat_line_active);
      chk("dat2 oe", k == 0, dat2_oe);
      chk("clk stop", k == 1, card_clk_stop);
      chk("dat2 out", 1'b0, dat2_out);
      irq <= 1'b1;
      tick(6);
      chk("int at gap", 1'b1, card_int_at_gap);
      chk("gap sample", 1'b1, gap_int_sample);
      irq <= 1'b0;
      bus(1'b0, `STAT_OFFSET, '0, 4'hf);
      chk("status", 32'h0000_0290, rd);
      wr(ctl | 32'h0002_0000, 4'hf);
      rdc();
      wr(ctl & 32'hfffe_ffff, 4'hf);
      tick(3);
      chk("halted", 1'b0, dat_line_active);
      wr(mc | 32'h0002_0000, 4'hf);
      tick(2);
      chk("restart", 1'b1, dat_line_active);
      mc[17] = 1'b0;
      rdc();
      pulse(last);
      tick(2);
      chk("done", 1'b0, dat_line_active);
    end
    wr(32'h0002_0000, 4'hf);
    wr(32'h0001_0000, 4'hf);
    pulse(go);
    tick(2);
    pulse(srst);
    tick(2);
    chk("srst act", 1'b0, dat_line_active);
    mc[16] = 1'b0;
    mc[17] = 1'b0;
    rdc();
    for (int h = 0; h < 2; h++) begin
      wr(32'(h) << 2, 4'hf);
      run <= 1'b1;
      @(posedge sd_clk_pin);
      @(posedge sd_clk_pin);
      n = 0;
      while (launch_strobe !== 1'b1) begin
        @(posedge core_clk);
        n++;
      end
      chk("launch edge", h, n < 7);
      @(posedge core_clk);
      run <= 1'b0;
    end
    finish_test();
  end
endmodule // sd_host_gap_power_control_bench
bind sd_gap_power_ctrl gap_ctrl_checker watch (.*);
